// >>> design/ipc_params.svh
`ifndef IPC_PARAMS_SVH
`define IPC_PARAMS_SVH

// Sizes
`define IPC_NSLOT       16
`define IPC_NPIN        7
`define IPC_NEST_DEPTH  4
`define IPC_PTR_W       3
`define IPC_SLOT_W      4
`define IPC_VEC_W       16

// Pin bits in the synchronised edge vector
`define IPC_PIN0        0
`define IPC_PIN1        1
`define IPC_PIN2        2
`define IPC_PIN3        3
`define IPC_PIN4        4
`define IPC_PIN5        5
`define IPC_PIN_NMI     6

// Default priority slots (0 ranks highest)
`define IPC_SLOT_P0     4'h0
`define IPC_SLOT_P1     4'h1
`define IPC_SLOT_P2     4'h2
`define IPC_SLOT_P3     4'h3
`define IPC_SLOT_WA     4'h4
`define IPC_SLOT_WB     4'h5
`define IPC_SLOT_1A     4'h6
`define IPC_SLOT_1B     4'h7
`define IPC_SLOT_2B     4'h8
`define IPC_SLOT_P4T3   4'h9
`define IPC_SLOT_P5AD   4'ha
`define IPC_SLOT_2A     4'hb
`define IPC_SLOT_RXE    4'hc
`define IPC_SLOT_RX     4'hd
`define IPC_SLOT_TX     4'he
`define IPC_SLOT_CSI    4'hf

// Vector table addresses
`define IPC_VEC_NMI     16'h0002
`define IPC_VEC_BRK     16'h003e
`define IPC_VEC_P0      16'h0006
`define IPC_VEC_P1      16'h0008
`define IPC_VEC_P2      16'h000a
`define IPC_VEC_P3      16'h000c
`define IPC_VEC_WA      16'h0014
`define IPC_VEC_WB      16'h0016
`define IPC_VEC_1A      16'h0018
`define IPC_VEC_1B      16'h001a
`define IPC_VEC_2B      16'h001c
`define IPC_VEC_P4T3    16'h000e
`define IPC_VEC_P5AD    16'h0010
`define IPC_VEC_2A      16'h0012
`define IPC_VEC_RXE     16'h0020
`define IPC_VEC_RX      16'h0022
`define IPC_VEC_TX      16'h0024
`define IPC_VEC_CSI     16'h0026

`endif

// >>> design/ipc_pkg.sv
package ipc_pkg;

    // Service entry and return sequencer states
    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_PUSH_PSW,
        ST_PUSH_PC,
        ST_FETCH,
        ST_POP_PC,
        ST_POP_PSW
    } ipc_state_t;

    // Level of a service held on the nesting stack
    typedef enum logic [1:0]
    {
        LV_LOW,
        LV_HIGH,
        LV_NMI,
        LV_SW
    } ipc_level_t;

endpackage

// >>> design/ipc_edge_if.sv
`timescale 1ns/100ps
`default_nettype none

// Raw pins in, one-cycle edge pulses out
interface ipc_edge_if #(parameter int W = 1);
    logic [W-1:0] pin_raw;      // Asynchronous pin levels
    logic [W-1:0] edge_pulse;   // Rising edge seen, one cycle

    modport det  (input pin_raw, output edge_pulse);
    modport user (output pin_raw, input edge_pulse);
endinterface

`default_nettype wire

// >>> design/ipc_edge_det.sv
`timescale 1ns/100ps
`default_nettype none

module ipc_edge_det #(parameter int W = 1)
(
    input  wire logic   clk,
    input  wire logic   rst,
    ipc_edge_if.det     pins
);

    logic [W-1:0] s1_q;     // First synchroniser stage
    logic [W-1:0] s2_q;     // Second synchroniser stage
    logic [W-1:0] s3_q;     // Previous synchronised level
    logic [W-1:0] edge_q;   // Registered rising edge

    // ------------------------------------------------------------
    // Synchroniser and edge detector
    // ------------------------------------------------------------
    // Only s2_q reads s1_q, so metastability stays in one stage
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            edge_q <= '0;
        end
        else
        begin
            s1_q   <= pins.pin_raw;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            edge_q <= s2_q & ~s3_q;
        end
    end

    assign pins.edge_pulse = edge_q;

endmodule

`default_nettype wire

// >>> design/ipc_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ipc_params.svh"

module ipc_top import ipc_pkg::*;
(
    input  wire logic           CLK,
    input  wire logic           SYS_RST,
    input  wire logic           NMI_PIN,
    input  wire logic           EXT_PIN0_REQUEST,
    input  wire logic           EXT_PIN1_REQUEST,
    input  wire logic           EXT_PIN2_REQUEST,
    input  wire logic           EXT_PIN3_REQUEST,
    input  wire logic           EXT_PIN4_REQUEST,
    input  wire logic           EXT_PIN5_REQUEST,
    input  wire logic           WIDE_TIMER_MATCH_A_REQUEST,
    input  wire logic           WIDE_TIMER_MATCH_B_REQUEST,
    input  wire logic           TIMER_ONE_MATCH_A_REQUEST,
    input  wire logic           TIMER_ONE_MATCH_B_REQUEST,
    input  wire logic           TIMER_TWO_MATCH_A_REQUEST,
    input  wire logic           TIMER_TWO_MATCH_B_REQUEST,
    input  wire logic           TIMER_THREE_MATCH_REQUEST,
    input  wire logic           CONVERSION_DONE_REQUEST,
    input  wire logic           ASYNC_RX_ERROR_REQUEST,
    input  wire logic           ASYNC_RX_DONE_REQUEST,
    input  wire logic           ASYNC_TX_DONE_REQUEST,
    input  wire logic           CSI_DONE_REQUEST,
    input  wire logic           BREAK_INSTRUCTION,
    input  wire logic [15:0]    LEVEL_HIGH,
    input  wire logic [15:0]    MASK,
    input  wire logic [15:0]    MACRO_SEL,
    input  wire logic           GLOBAL_IE,
    input  wire logic           SEL_SLOT9_TIMER,
    input  wire logic           SEL_SLOT10_CONV,
    input  wire logic           CPU_READY,
    input  wire logic           RETURN_FROM_SERVICE,
    input  wire logic           MACRO_DONE,
    input  wire logic           MACRO_LAST,
    output logic                STACK_PUSH,
    output logic                STACK_POP,
    output logic                STACK_PSW,
    output logic                VECTOR_FETCH,
    output logic [15:0]         VECTOR_ADDR,
    output logic                MACRO_REQ,
    output logic [3:0]          MACRO_SLOT,
    output logic [15:0]         PENDING,
    output logic                NMI_IN_SERVICE,
    output logic                TIMER_ONE_CAPTURE,
    output logic                TIMER_TWO_CAPTURE,
    output logic                TIMER_TWO_COUNT,
    output logic                WIDE_TIMER_CAPTURE,
    output logic                CONVERSION_START
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    ipc_edge_if #(.W(`IPC_NPIN)) pin_edges ();     // Pin edge carrier

    logic [`IPC_NPIN-1:0]   pin_ev;         // Synchronised pin edges
    logic [`IPC_NSLOT-1:0]  slot_evt;       // Request pulse per slot
    logic [`IPC_NSLOT-1:0]  pend_q;         // Latched requests
    logic [`IPC_NSLOT-1:0]  force_vec_q;    // Macro ended, serve vectored
    logic                   nmi_pend_q;     // Latched non-maskable edge
    logic                   brk_pend_q;     // Latched break request
    ipc_state_t             st_q;           // Entry/return sequencer
    ipc_level_t             nest_q [`IPC_NEST_DEPTH];  // Nesting stack
    logic [`IPC_PTR_W-1:0]  ptr_q;          // Nesting depth
    logic                   macro_busy_q;   // Macro transfer running
    logic [`IPC_SLOT_W-1:0] macro_slot_q;   // Slot under macro service
    logic [15:0]            vec_q;          // Vector address to fetch
    logic                   hi_busy;        // High or NMI in service
    logic                   lo_busy;        // Any maskable/NMI in service
    logic                   nmi_busy;       // NMI in service
    logic [`IPC_NSLOT-1:0]  elig;           // Slot may be taken now
    logic [`IPC_NSLOT-1:0]  as_macro;       // Slot served as macro
    logic                   win_any;        // Some slot wins
    logic [`IPC_SLOT_W-1:0] win_slot;       // Winning slot
    logic                   can_take;       // Sequencer free to accept
    logic                   take_nmi;       // Accept NMI this cycle
    logic                   take_brk;       // Accept break this cycle
    logic                   take_slot;      // Accept a slot this cycle
    logic                   take_vec;       // Any vectored acceptance
    logic                   start_ret;      // Begin return sequence
    ipc_level_t             take_lvl;       // Level pushed on accept

    // ------------------------------------------------------------
    // Pin synchronisers and edge detectors
    // ------------------------------------------------------------
    assign pin_edges.pin_raw = {NMI_PIN, EXT_PIN5_REQUEST,
                                EXT_PIN4_REQUEST, EXT_PIN3_REQUEST,
                                EXT_PIN2_REQUEST, EXT_PIN1_REQUEST,
                                EXT_PIN0_REQUEST};

    ipc_edge_det #(.W(`IPC_NPIN)) u_edges
    (
        .clk  (CLK),
        .rst  (SYS_RST),
        .pins (pin_edges.det)
    );

    assign pin_ev = pin_edges.edge_pulse;

    // Edge pulses double as timer and converter triggers
    assign TIMER_ONE_CAPTURE  = pin_ev[`IPC_PIN0];
    assign TIMER_TWO_CAPTURE  = pin_ev[`IPC_PIN1];
    assign TIMER_TWO_COUNT    = pin_ev[`IPC_PIN2];
    assign WIDE_TIMER_CAPTURE = pin_ev[`IPC_PIN3];
    assign CONVERSION_START   = pin_ev[`IPC_PIN5];

    // ------------------------------------------------------------
    // Source to default priority slot mapping
    // ------------------------------------------------------------
    always_comb
    begin
        slot_evt = '0;
        slot_evt[`IPC_SLOT_P0] = pin_ev[`IPC_PIN0];
        slot_evt[`IPC_SLOT_P1] = pin_ev[`IPC_PIN1];
        slot_evt[`IPC_SLOT_P2] = pin_ev[`IPC_PIN2];
        slot_evt[`IPC_SLOT_P3] = pin_ev[`IPC_PIN3];
        slot_evt[`IPC_SLOT_WA] = WIDE_TIMER_MATCH_A_REQUEST;
        slot_evt[`IPC_SLOT_WB] = WIDE_TIMER_MATCH_B_REQUEST;
        slot_evt[`IPC_SLOT_1A] = TIMER_ONE_MATCH_A_REQUEST;
        slot_evt[`IPC_SLOT_1B] = TIMER_ONE_MATCH_B_REQUEST;
        slot_evt[`IPC_SLOT_2B] = TIMER_TWO_MATCH_B_REQUEST;
        // Shared slots: the unselected source is ignored
        slot_evt[`IPC_SLOT_P4T3] = SEL_SLOT9_TIMER ?
            TIMER_THREE_MATCH_REQUEST : pin_ev[`IPC_PIN4];
        slot_evt[`IPC_SLOT_P5AD] = SEL_SLOT10_CONV ?
            CONVERSION_DONE_REQUEST : pin_ev[`IPC_PIN5];
        slot_evt[`IPC_SLOT_2A]  = TIMER_TWO_MATCH_A_REQUEST;
        slot_evt[`IPC_SLOT_RXE] = ASYNC_RX_ERROR_REQUEST;
        slot_evt[`IPC_SLOT_RX]  = ASYNC_RX_DONE_REQUEST;
        slot_evt[`IPC_SLOT_TX]  = ASYNC_TX_DONE_REQUEST;
        slot_evt[`IPC_SLOT_CSI] = CSI_DONE_REQUEST;
    end

    // ------------------------------------------------------------
    // Levels now in service, from the nesting stack
    // ------------------------------------------------------------
    always_comb
    begin
        hi_busy  = 1'b0;
        lo_busy  = 1'b0;
        nmi_busy = 1'b0;
        for (int i = 0; i < `IPC_NEST_DEPTH; i++)
        begin
            if (ptr_q > 3'(i))
            begin
                case (nest_q[i])
                    LV_NMI:
                    begin
                        nmi_busy = 1'b1;
                        hi_busy  = 1'b1;
                        lo_busy  = 1'b1;
                    end
                    LV_HIGH:
                    begin
                        hi_busy = 1'b1;
                        lo_busy = 1'b1;
                    end
                    LV_LOW:  lo_busy = 1'b1;
                    default: ;  // Break does not block maskables
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Arbiter
    // ------------------------------------------------------------
    // Macro requests skip the level hold; vectored ones need IE
    always_comb
    begin
        as_macro = MACRO_SEL & ~force_vec_q;
        for (int s = 0; s < `IPC_NSLOT; s++)
        begin
            elig[s] = pend_q[s] & ~MASK[s] &
                      (as_macro[s] |
                       (GLOBAL_IE & (LEVEL_HIGH[s] ? ~hi_busy
                                                   : ~lo_busy)));
        end
    end

    // High level wins first, then lowest slot number
    always_comb
    begin
        win_any  = 1'b0;
        win_slot = '0;
        for (int s = `IPC_NSLOT - 1; s >= 0; s--)
        begin
            if (elig[s] & ~LEVEL_HIGH[s])
            begin
                win_any  = 1'b1;
                win_slot = 4'(s);
            end
        end
        for (int s = `IPC_NSLOT - 1; s >= 0; s--)
        begin
            if (elig[s] & LEVEL_HIGH[s])
            begin
                win_any  = 1'b1;
                win_slot = 4'(s);
            end
        end
    end

    // Return first, then NMI, then break, then maskable slots
    assign can_take  = (st_q == ST_IDLE) & ~macro_busy_q &
                       (ptr_q != 3'(`IPC_NEST_DEPTH));
    assign start_ret = (st_q == ST_IDLE) & RETURN_FROM_SERVICE &
                       (ptr_q != '0);
    assign take_nmi  = can_take & ~start_ret &
                       nmi_pend_q & ~nmi_busy;
    assign take_brk  = can_take & ~start_ret & ~take_nmi &
                       brk_pend_q;
    assign take_slot = can_take & ~start_ret & ~take_nmi &
                       ~take_brk & win_any;
    assign take_vec  = take_nmi | take_brk |
                       (take_slot & ~as_macro[win_slot]);
    assign take_lvl  = take_nmi ? LV_NMI :
                       take_brk ? LV_SW  :
                       LEVEL_HIGH[win_slot] ? LV_HIGH : LV_LOW;

    // Vector address of each slot
    function automatic logic [15:0] slot_vec(input logic [3:0] s);
        case (s)
            `IPC_SLOT_P0:   slot_vec = `IPC_VEC_P0;
            `IPC_SLOT_P1:   slot_vec = `IPC_VEC_P1;
            `IPC_SLOT_P2:   slot_vec = `IPC_VEC_P2;
            `IPC_SLOT_P3:   slot_vec = `IPC_VEC_P3;
            `IPC_SLOT_WA:   slot_vec = `IPC_VEC_WA;
            `IPC_SLOT_WB:   slot_vec = `IPC_VEC_WB;
            `IPC_SLOT_1A:   slot_vec = `IPC_VEC_1A;
            `IPC_SLOT_1B:   slot_vec = `IPC_VEC_1B;
            `IPC_SLOT_2B:   slot_vec = `IPC_VEC_2B;
            `IPC_SLOT_P4T3: slot_vec = `IPC_VEC_P4T3;
            `IPC_SLOT_P5AD: slot_vec = `IPC_VEC_P5AD;
            `IPC_SLOT_2A:   slot_vec = `IPC_VEC_2A;
            `IPC_SLOT_RXE:  slot_vec = `IPC_VEC_RXE;
            `IPC_SLOT_RX:   slot_vec = `IPC_VEC_RX;
            `IPC_SLOT_TX:   slot_vec = `IPC_VEC_TX;
            default:        slot_vec = `IPC_VEC_CSI;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Request latches
    // ------------------------------------------------------------
    // A new event in the clearing cycle keeps the request pending
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            pend_q <= '0;
        end
        else
        begin
            for (int s = 0; s < `IPC_NSLOT; s++)
            begin
                if (slot_evt[s] |
                    (MACRO_DONE & MACRO_LAST & macro_busy_q &
                     (macro_slot_q == 4'(s))))
                    pend_q[s] <= 1'b1;
                else if (take_slot & (win_slot == 4'(s)))
                    pend_q[s] <= 1'b0;
            end
        end
    end

    // Last macro transfer turns the next service vectored
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            force_vec_q <= '0;
        end
        else
        begin
            for (int s = 0; s < `IPC_NSLOT; s++)
            begin
                if (MACRO_DONE & MACRO_LAST & macro_busy_q &
                    (macro_slot_q == 4'(s)))
                    force_vec_q[s] <= 1'b1;
                else if (take_slot & (win_slot == 4'(s)))
                    force_vec_q[s] <= 1'b0;
            end
        end
    end

    // Non-maskable and break latches
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            nmi_pend_q <= 1'b0;
            brk_pend_q <= 1'b0;
        end
        else
        begin
            if (pin_ev[`IPC_PIN_NMI])
                nmi_pend_q <= 1'b1;
            else if (take_nmi)
                nmi_pend_q <= 1'b0;
            if (BREAK_INSTRUCTION)
                brk_pend_q <= 1'b1;
            else if (take_brk)
                brk_pend_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Macro service channel
    // ------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            macro_busy_q <= 1'b0;
            macro_slot_q <= '0;
        end
        else if (take_slot & as_macro[win_slot])
        begin
            macro_busy_q <= 1'b1;
            macro_slot_q <= win_slot;
        end
        else if (MACRO_DONE)
        begin
            macro_busy_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Nesting stack
    // ------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            ptr_q <= '0;
            for (int i = 0; i < `IPC_NEST_DEPTH; i++)
                nest_q[i] <= LV_LOW;
        end
        else if (take_vec)
        begin
            nest_q[ptr_q[1:0]] <= take_lvl;
            ptr_q              <= ptr_q + 3'h1;
        end
        else if ((st_q == ST_POP_PSW) & CPU_READY)
        begin
            ptr_q <= ptr_q - 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Entry and return sequencer
    // ------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            st_q  <= ST_IDLE;
            vec_q <= '0;
        end
        else
        begin
            case (st_q)
                ST_IDLE:
                begin
                    if (start_ret)
                        st_q <= ST_POP_PC;
                    else if (take_vec)
                    begin
                        st_q  <= ST_PUSH_PSW;
                        vec_q <= take_nmi ? `IPC_VEC_NMI :
                                 take_brk ? `IPC_VEC_BRK :
                                 slot_vec(win_slot);
                    end
                end
                ST_PUSH_PSW: if (CPU_READY) st_q <= ST_PUSH_PC;
                ST_PUSH_PC:  if (CPU_READY) st_q <= ST_FETCH;
                ST_FETCH:    if (CPU_READY) st_q <= ST_IDLE;
                ST_POP_PC:   if (CPU_READY) st_q <= ST_POP_PSW;
                ST_POP_PSW:  if (CPU_READY) st_q <= ST_IDLE;
                default:     st_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign STACK_PUSH     = (st_q == ST_PUSH_PSW) | (st_q == ST_PUSH_PC);
    assign STACK_POP      = (st_q == ST_POP_PC) | (st_q == ST_POP_PSW);
    assign STACK_PSW      = (st_q == ST_PUSH_PSW) | (st_q == ST_POP_PSW);
    assign VECTOR_FETCH   = (st_q == ST_FETCH);
    assign VECTOR_ADDR    = vec_q;
    assign MACRO_REQ      = macro_busy_q;
    assign MACRO_SLOT     = macro_slot_q;
    assign PENDING        = pend_q;
    assign NMI_IN_SERVICE = nmi_busy;

endmodule

`default_nettype wire

// >>> dv/ipc_props.sv
`timescale 1ns/100ps
`default_nettype none
module ipc_props (
    input wire logic        CLK, SYS_RST, CPU_READY, STACK_PUSH, STACK_POP, STACK_PSW,
    input wire logic        VECTOR_FETCH, MACRO_REQ, MACRO_DONE, EXT_PIN0_REQUEST,
    input wire logic        TIMER_ONE_CAPTURE,
    input wire logic        TIMER_TWO_CAPTURE, TIMER_TWO_COUNT, WIDE_TIMER_CAPTURE,
    input wire logic [15:0] VECTOR_ADDR, PENDING
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // ----------------------------------------
    // Entry and return sequence
    // ----------------------------------------
    property p_psw_pc;
        STACK_PUSH && STACK_PSW && CPU_READY |=> STACK_PUSH && !STACK_PSW;
    endproperty
    a_psw_pc: assert property (p_psw_pc) else $error("PC push missing");
    property p_pc_fetch;
        STACK_PUSH && !STACK_PSW && CPU_READY |=> VECTOR_FETCH && !STACK_PUSH;
    endproperty
    a_pc_fetch: assert property (p_pc_fetch) else $error("fetch missing");
    property p_addr;
        VECTOR_FETCH |-> !VECTOR_ADDR[0] && VECTOR_ADDR inside {[16'h0002:16'h003e]};
    endproperty
    a_addr: assert property (p_addr) else $error("vector outside table");
    property p_pop;
        STACK_POP && !STACK_PSW && CPU_READY |=> STACK_POP && STACK_PSW;
    endproperty
    a_pop: assert property (p_pop) else $error("status pop missing");
    // ----------------------------------------
    // Pin edge, latching, macro transfer
    // ----------------------------------------
    property p_cap;
        $rose(EXT_PIN0_REQUEST) |-> ##[1:4] TIMER_ONE_CAPTURE;
    endproperty
    a_cap: assert property (p_cap) else $error("no capture pulse");
    property p_pend;
        TIMER_ONE_CAPTURE |=> PENDING[0];
    endproperty
    a_pend: assert property (p_pend) else $error("request not latched");
    property p_trig;
        TIMER_TWO_CAPTURE || TIMER_TWO_COUNT || WIDE_TIMER_CAPTURE |=>
            PENDING[3:1] == $past({WIDE_TIMER_CAPTURE, TIMER_TWO_COUNT, TIMER_TWO_CAPTURE});
    endproperty
    a_trig: assert property (p_trig) else $error("pin edge in wrong slot");
    property p_quiet;
        MACRO_REQ |-> !STACK_PUSH && !STACK_POP;
    endproperty
    a_quiet: assert property (p_quiet) else $error("stack used by macro");
    property p_mend;
        MACRO_REQ && MACRO_DONE |=> !MACRO_REQ;
    endproperty
    a_mend: assert property (p_mend) else $error("macro not released");
    c_fetch: cover property (VECTOR_FETCH);
    c_macro: cover property (MACRO_REQ);
    c_pop: cover property (STACK_POP && STACK_PSW);
endmodule
bind ipc_top ipc_props u_props (.*);
`default_nettype wire

// >>> dv/ipc_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module ipc_cpu_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic slow,
    input  wire logic macro_req,
    output logic      ready_q,
    output logic      done_q
);
    logic [1:0] cnt_q; // Macro transfer length
    // Step acknowledge, every other edge when slow
    always_ff @(posedge clk)
        ready_q <= !rst && (!slow || !ready_q);
    // Transfer runs four cycles, then one done pulse
    always_ff @(posedge clk)
    begin
        cnt_q  <= (rst || !macro_req) ? 2'h0 : cnt_q + 2'h1;
        done_q <= !rst && macro_req && !done_q && cnt_q == 2'h3;
    end
endmodule
`default_nettype wire

// >>> dv/interrupt_priority_controller_test.sv
`timescale 1ns/100ps
`default_nettype none
module interrupt_priority_controller_test import ipc_pkg::*;;
    logic CLK = 0, SYS_RST = 1, GLOBAL_IE = 1, RETURN_FROM_SERVICE = 0, CPU_READY, MACRO_DONE;
    logic STACK_PUSH, STACK_POP, STACK_PSW, VECTOR_FETCH, MACRO_REQ, NMI_IN_SERVICE;
    logic [15:0] LEVEL_HIGH = 0, MASK = 0, MACRO_SEL = 0, VECTOR_ADDR, PENDING, hit = 0;
    logic [6:0]  pin = 0;  // Pin levels, bit 6 non-maskable
    logic [3:0]  MACRO_SLOT;
    logic        sel = 0, break_instruction = 0, slow = 0, last = 0;
    int          errors = 0, checked = 0;
    logic [15:0] vt [16] = '{16'h0006, 16'h0008, 16'h000a, 16'h000c, 16'h0014, 16'h0016,
        16'h0018, 16'h001a, 16'h001c, 16'h000e, 16'h0010, 16'h0012, 16'h0020, 16'h0022,
        16'h0024, 16'h0026};
    always #5 CLK = ~CLK;
    ipc_top dut (.CLK, .SYS_RST, .NMI_PIN(pin[6]), .EXT_PIN0_REQUEST(pin[0]),
        .EXT_PIN1_REQUEST(pin[1]), .EXT_PIN2_REQUEST(pin[2]), .EXT_PIN3_REQUEST(pin[3]),
        .EXT_PIN4_REQUEST(pin[4]), .EXT_PIN5_REQUEST(pin[5]),
        .WIDE_TIMER_MATCH_A_REQUEST(hit[4]), .WIDE_TIMER_MATCH_B_REQUEST(hit[5]),
        .TIMER_ONE_MATCH_A_REQUEST(hit[6]), .TIMER_ONE_MATCH_B_REQUEST(hit[7]),
        .TIMER_TWO_MATCH_B_REQUEST(hit[8]), .TIMER_THREE_MATCH_REQUEST(hit[9]),
        .CONVERSION_DONE_REQUEST(hit[10]), .TIMER_TWO_MATCH_A_REQUEST(hit[11]),
        .ASYNC_RX_ERROR_REQUEST(hit[12]), .ASYNC_RX_DONE_REQUEST(hit[13]),
        .ASYNC_TX_DONE_REQUEST(hit[14]), .CSI_DONE_REQUEST(hit[15]), .BREAK_INSTRUCTION(break_instruction),
        .LEVEL_HIGH, .MASK, .MACRO_SEL, .GLOBAL_IE, .SEL_SLOT9_TIMER(sel),
        .SEL_SLOT10_CONV(sel), .CPU_READY, .RETURN_FROM_SERVICE, .MACRO_DONE,
        .MACRO_LAST(last), .STACK_PUSH, .STACK_POP, .STACK_PSW, .VECTOR_FETCH, .VECTOR_ADDR,
        .MACRO_REQ, .MACRO_SLOT, .PENDING, .NMI_IN_SERVICE, .TIMER_ONE_CAPTURE(),
        .TIMER_TWO_CAPTURE(), .TIMER_TWO_COUNT(), .WIDE_TIMER_CAPTURE(), .CONVERSION_START());
    ipc_cpu_model cpu (.clk(CLK), .rst(SYS_RST), .slow(slow), .macro_req(MACRO_REQ),
        .ready_q(CPU_READY), .done_q(MACRO_DONE));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Sources pulse one cycle; pins stay high until the return
    task automatic kick(input logic [15:0] h, input logic [6:0] p);
        @(posedge CLK);
        hit <= h;
        pin <= p;
        @(posedge CLK);
        hit <= 16'h0000;
    endtask
    // Bounded wait for the fetch step, then its address
    task automatic fetch(input logic [15:0] exp);
        for (int i = 0; i < 60 && VECTOR_FETCH !== 1'b1; i++)
            @(posedge CLK);
        cmp({VECTOR_FETCH, VECTOR_ADDR[14:0]}, {1'b1, exp[14:0]});
    endtask
    // Return once the entry steps are over
    task automatic ret;
        @(posedge CLK);
        while (VECTOR_FETCH !== 1'b0)
            @(posedge CLK);
        RETURN_FROM_SERVICE <= 1'b1;
        pin <= 7'h00;
        @(posedge CLK);
        RETURN_FROM_SERVICE <= 1'b0;
        repeat (4) @(posedge CLK);
    endtask
    // Every slot source alone, both alternatives of slots 9 and 10
    task automatic t_order;
        for (int s = 0; s < 18; s++)
        begin
            sel <= s < 16;
            kick(s > 3 && s < 16 ? 16'h1 << s : 16'h0,
                s < 4 ? 7'h1 << s : (s > 15 ? 7'h1 << (s - 12) : 7'h0));
            fetch(vt[s > 15 ? s - 7 : s]);
            ret();
        end
    endtask
    // Ties go by fixed order; high level overrides it
    task automatic t_tie;
        kick(16'h4010, 7'h00);
        fetch(vt[4]);
        cmp(PENDING & 16'h4000, 16'h4000);
        ret();
        fetch(vt[14]);
        ret();
        LEVEL_HIGH <= 16'h4000;
        slow <= 1'b1;
        kick(16'h4010, 7'h00);
        fetch(vt[14]);
        ret();
        fetch(vt[4]);
        ret();
    endtask
    // Macro transfer nests into a vectored service
    task automatic t_macro;
        MACRO_SEL <= 16'h4000;
        kick(16'h0010, 7'h00);
        fetch(vt[4]);
        kick(16'h4000, 7'h00);
        for (int i = 0; i < 30 && MACRO_REQ !== 1'b1; i++)
            @(posedge CLK);
        cmp({MACRO_REQ, 11'h0, MACRO_SLOT}, 16'h800e);
        for (int i = 0; i < 30 && MACRO_REQ !== 1'b0; i++)
            @(posedge CLK);
        cmp({15'h0, MACRO_REQ}, 16'h0000);
        // Last transfer hands the slot back as a vectored request
        last <= 1'b1;
        kick(16'h4000, 7'h00);
        fetch(vt[14]);
        ret();
        last <= 1'b0;
        ret();
    endtask
    // Break, then the pin edge that ignores every mask
    task automatic t_nmi;
        slow <= 1'b0;
        break_instruction <= 1'b1;
        @(posedge CLK);
        break_instruction <= 1'b0;
        fetch(16'h003e);
        ret();
        MASK <= 16'hffff;
        GLOBAL_IE <= 1'b0;
        kick(16'h0010, 7'h40);
        fetch(16'h0002);
        cmp({15'h0, NMI_IN_SERVICE}, 16'h0001);
        ret();
        cmp(PENDING, 16'h0010);
    endtask
    task automatic conclude;
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge CLK);
        SYS_RST <= 1'b0;
        @(posedge CLK);
        t_order();
        t_tie();
        t_macro();
        t_nmi();
        conclude();
    end
    // Watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge CLK);
        errors++;
        conclude();
    end
endmodule
`default_nettype wire
